// [src/tsi_pkg.sv]
// package for the three source interrupt unit: register map, fields, reset values
package tsi_pkg;

    // ****************************************************************
    // register indices; the bus byte address is four times the index
    // ****************************************************************
    localparam logic [7:0] IDX_EDGE_SELECT = 8'hbf;
    localparam logic [7:0] IDX_REQUEST_FLAGS = 8'hc8;
    localparam logic [7:0] IDX_SOURCE_ENABLES = 8'hc9;
    localparam logic [7:0] IDX_STACK_GIE = 8'hdf;
    localparam logic [7:0] IDX_SAVE_STATUS = 8'he0;
    localparam logic [11:0] ADDR_EDGE_SELECT = {2'h0, IDX_EDGE_SELECT, 2'h0};
    localparam logic [11:0] ADDR_REQUEST_FLAGS = {2'h0, IDX_REQUEST_FLAGS, 2'h0};
    localparam logic [11:0] ADDR_SOURCE_ENABLES = {2'h0, IDX_SOURCE_ENABLES, 2'h0};
    localparam logic [11:0] ADDR_STACK_GIE = {2'h0, IDX_STACK_GIE, 2'h0};
    localparam logic [11:0] ADDR_SAVE_STATUS = {2'h0, IDX_SAVE_STATUS, 2'h0};

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int BIT_PIN = 0;
    localparam int BIT_TIMER_A = 4;
    localparam int BIT_TIMER_B = 5;
    localparam int BIT_GIE = 7;
    localparam int EDGE_LSB = 3;
    localparam int BIT_TIMEOUT = 4;
    localparam int BIT_POWERDOWN = 3;
    localparam logic [7:0] SRC_MASK = 8'h31;
    localparam logic [7:0] EDGE_MASK = 8'h18;
    localparam logic [7:0] STACK_MASK = 8'h83;
    localparam logic [7:0] FLAG_KEEP_MASK = 8'h18;

    // ****************************************************************
    // reset values and encodings
    // ****************************************************************
    localparam logic [7:0] RST_EDGE = 8'h10;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_ENABLES = 8'h00;
    localparam logic [7:0] RST_STACK = 8'h03;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [15:0] IRQ_VECTOR = 16'h0008;
    localparam logic [31:0] PSLVERR_NONE = 32'h0000_0000;

    // core-side command group
    typedef struct packed {
        logic boundary;
        logic takeAck;
        logic retIrq;
        logic saveOp;
        logic restoreOp;
    } tsi_core_cmd_t;

    // state saved by the save instruction
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] program_flag_reg;
    } tsi_save_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_VECT = 2'b10
    } tsi_state_t;

endpackage : tsi_pkg

// [src/tsi_unit.sv]
// interrupt unit with three request sources, apb registers and save buffer
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module tsi_unit (
    // clock and reset
    input wire logic sysClk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // source events (same clock) and external pin
    input wire logic timerAOvf,
    input wire logic timerBOvf,
    input wire logic extPin,
    input wire logic powerDown,
    // core sequencing
    input wire tsi_pkg::tsi_core_cmd_t coreCmd,
    input wire logic [7:0] accIn,
    input wire logic [7:0] pflagIn,
    output logic irqReq,
    output logic vectorLoad,
    output logic [15:0] vectorAddr,
    output logic restoreValid,
    output logic [7:0] accOut,
    output logic [7:0] pflagOut,
    output logic wakeUp
);

    // ****************************************************************
    // pin synchroniser and edge detect
    // ****************************************************************
    logic pinMeta_q, pinSync_q, pinLast_q;
    logic [2:0] armed_q;
    logic rise, fall, edgeHit;
    logic [1:0] edgeField;

    always_ff @(posedge sysClk or posedge rst) begin
        if (rst) begin
            pinMeta_q <= 1'b0;
            pinSync_q <= 1'b0;
            pinLast_q <= 1'b0;
            armed_q <= 3'h0;
        end else begin
            pinMeta_q <= extPin;
            pinSync_q <= pinMeta_q;
            pinLast_q <= pinSync_q;
            armed_q <= {armed_q[1:0], 1'b1};
        end
    end

    // the chain resets low whatever level the pin idles at, so edges are
    // ignored until it holds real pin samples; no false edge after reset
    assign rise = armed_q[2] & pinSync_q & ~pinLast_q;
    assign fall = armed_q[2] & ~pinSync_q & pinLast_q;

    always_comb begin
        case (edgeField)
            tsi_pkg::EDGE_RISE: edgeHit = rise;
            tsi_pkg::EDGE_FALL: edgeHit = fall;
            tsi_pkg::EDGE_BOTH: edgeHit = rise | fall;
            default: edgeHit = 1'b0;
        endcase
    end

    // ****************************************************************
    // registers: next-state logic
    // ****************************************************************
    logic [7:0] edge_q, edge_d;
    logic [7:0] flags_q, flags_d;
    logic [7:0] enables_q, enables_d;
    logic [7:0] stack_q, stack_d;
    logic wakeLatch_q, wakeLatch_d;
    logic wake_d;
    tsi_pkg::tsi_save_t save_q, save_d;
    tsi_pkg::tsi_state_t state_q, state_d;
    logic wr, rd;
    logic [7:0] wbyte, events, pending;
    logic [31:0] prdata_d;
    logic irq_d, vload_d, rvalid_d;
    logic pready_d, pslverr_d;
    logic [15:0] vaddr_d;
    logic [7:0] accOut_d, pflagOut_d;

    assign edgeField = edge_q[tsi_pkg::EDGE_LSB +: 2];
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;
    assign wbyte = pwdata[7:0];

    always_comb begin
        events = 8'h00;
        events[tsi_pkg::BIT_PIN] = edgeHit | wakeLatch_q;
        events[tsi_pkg::BIT_TIMER_A] = timerAOvf;
        events[tsi_pkg::BIT_TIMER_B] = timerBOvf;
    end

    // shared vector, no priority among sources
    assign pending = flags_q & enables_q & tsi_pkg::SRC_MASK;

    always_comb begin
        edge_d = edge_q;
        enables_d = enables_q;
        stack_d = stack_q;
        flags_d = flags_q;
        state_d = state_q;
        if (wr) begin
            case (paddr)
                tsi_pkg::ADDR_EDGE_SELECT: edge_d = wbyte & tsi_pkg::EDGE_MASK;
                tsi_pkg::ADDR_SOURCE_ENABLES: enables_d = wbyte & tsi_pkg::SRC_MASK;
                tsi_pkg::ADDR_REQUEST_FLAGS: flags_d = wbyte & tsi_pkg::SRC_MASK;
                tsi_pkg::ADDR_STACK_GIE: stack_d = wbyte & tsi_pkg::STACK_MASK;
                default: ;
            endcase
        end
        // an event in the same cycle as a software clear still wins
        flags_d = flags_d | events;
        case (state_q)
            tsi_pkg::ST_RUN: begin
                // a push counts the level field down, a return counts it back up
                if (coreCmd.takeAck) begin
                    stack_d[1:0] = stack_q[1:0] - 2'h1;
                    stack_d[tsi_pkg::BIT_GIE] = 1'b0;
                    state_d = tsi_pkg::ST_VECT;
                end
            end
            tsi_pkg::ST_VECT: begin
                if (coreCmd.retIrq) begin
                    stack_d[1:0] = stack_q[1:0] + 2'h1;
                    stack_d[tsi_pkg::BIT_GIE] = 1'b1;
                    state_d = tsi_pkg::ST_RUN;
                end
            end
            default: state_d = tsi_pkg::ST_RUN;
        endcase
    end

    // ****************************************************************
    // wake-up latch
    // ****************************************************************
    always_comb begin
        wakeLatch_d = wakeLatch_q;
        wake_d = 1'b0;
        // the pin edge in power-down is held so it is served after wake-up
        if (powerDown && edgeHit) begin
            wakeLatch_d = 1'b1;
            wake_d = 1'b1;
        end else if (!powerDown) begin
            wakeLatch_d = 1'b0;
        end
    end

    always_ff @(posedge sysClk or posedge rst) begin
        if (rst) begin
            wakeLatch_q <= 1'b0;
        end else begin
            wakeLatch_q <= wakeLatch_d;
        end
    end

    // ****************************************************************
    // save buffer
    // ****************************************************************
    // one level only: a second save overwrites the first
    always_comb begin
        save_d = save_q;
        if (coreCmd.saveOp) begin
            save_d.acc = accIn;
            save_d.program_flag_reg = pflagIn;
        end
    end

    always_ff @(posedge sysClk or posedge rst) begin
        if (rst) begin
            save_q <= '0;
        end else begin
            save_q <= save_d;
        end
    end

    // ****************************************************************
    // outputs: next values
    // ****************************************************************
    always_comb begin
        // request held back except at instruction boundaries
        irq_d = coreCmd.boundary && stack_q[tsi_pkg::BIT_GIE]
                && (pending != 8'h00) && (state_q == tsi_pkg::ST_RUN)
                && !coreCmd.takeAck;
        vload_d = (state_q == tsi_pkg::ST_RUN) && coreCmd.takeAck;
        vaddr_d = tsi_pkg::IRQ_VECTOR;
        rvalid_d = coreCmd.restoreOp;
        accOut_d = coreCmd.restoreOp ? save_q.acc : accOut;
        // timeout and power-down bits keep their live values
        pflagOut_d = coreCmd.restoreOp ?
            ((save_q.program_flag_reg & ~tsi_pkg::FLAG_KEEP_MASK) | (pflagIn & tsi_pkg::FLAG_KEEP_MASK)) :
            pflagOut;
        // ready in the first access cycle: every transfer takes two cycles
        pready_d = psel & ~penable;
        // every address answers; unmapped ones read zero and ignore writes
        pslverr_d = |tsi_pkg::PSLVERR_NONE;
        prdata_d = 32'h0000_0000;
        if (rd) begin
            case (paddr)
                tsi_pkg::ADDR_EDGE_SELECT: prdata_d = {24'h0, edge_q};
                tsi_pkg::ADDR_REQUEST_FLAGS: prdata_d = {24'h0, flags_q};
                tsi_pkg::ADDR_SOURCE_ENABLES: prdata_d = {24'h0, enables_q};
                tsi_pkg::ADDR_STACK_GIE: prdata_d = {24'h0, stack_q};
                tsi_pkg::ADDR_SAVE_STATUS: prdata_d = {24'h0, save_q.program_flag_reg};
                default: prdata_d = 32'h0000_0000;
            endcase
        end else if (psel && penable) begin
            // held through the access phase so the master finds it at ready
            prdata_d = prdata;
        end
    end

    // ****************************************************************
    // registered state
    // ****************************************************************
    always_ff @(posedge sysClk or posedge rst) begin
        if (rst) begin
            edge_q <= tsi_pkg::RST_EDGE;
            flags_q <= tsi_pkg::RST_FLAGS;
            enables_q <= tsi_pkg::RST_ENABLES;
            stack_q <= tsi_pkg::RST_STACK;
            state_q <= tsi_pkg::ST_RUN;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irqReq <= 1'b0;
            vectorLoad <= 1'b0;
            vectorAddr <= tsi_pkg::IRQ_VECTOR;
            restoreValid <= 1'b0;
            accOut <= 8'h00;
            pflagOut <= 8'h00;
            wakeUp <= 1'b0;
        end else begin
            edge_q <= edge_d;
            flags_q <= flags_d;
            enables_q <= enables_d;
            stack_q <= stack_d;
            state_q <= state_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
            irqReq <= irq_d;
            vectorLoad <= vload_d;
            vectorAddr <= vaddr_d;
            restoreValid <= rvalid_d;
            accOut <= accOut_d;
            pflagOut <= pflagOut_d;
            wakeUp <= wake_d;
        end
    end

endmodule : tsi_unit

`default_nettype wire

// [tb/tsi_unit_props.sv]
// port checker for the interrupt unit
`timescale 1ns/100ps
`default_nettype none
module tsi_unit_props (
    // clock, reset, apb
    input wire logic sysClk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // core side
    input wire tsi_pkg::tsi_core_cmd_t coreCmd,
    input wire logic [7:0] pflagIn,
    input wire logic irqReq,
    input wire logic vectorLoad,
    input wire logic [15:0] vectorAddr,
    input wire logic restoreValid,
    input wire logic [7:0] pflagOut,
    input wire logic powerDown,
    input wire logic wakeUp
);
    default clocking cb @(posedge sysClk);
    endclocking
    default disable iff (rst);
    AST_APB_WAIT: assert property (psel && !penable |=> pready)
        else $error("apb access not answered at once");
    AST_NO_ERR: assert property (pready |-> !pslverr)
        else $error("apb error response");
    AST_VEC_ADDR: assert property (vectorLoad |-> vectorAddr == 16'h0008)
        else $error("wrong vector address");
    AST_TAKE: assert property (coreCmd.takeAck |=> vectorLoad ##1 !vectorLoad)
        else $error("accepted request not vectored in one pulse");
    AST_VEC_CAUSE: assert property (vectorLoad |-> $past(coreCmd.takeAck))
        else $error("vector load without acceptance");
    AST_HOLD_OFF: assert property (vectorLoad |=> !irqReq [*2])
        else $error("request raised while in service");
    AST_RESTORE: assert property (coreCmd.restoreOp |=> restoreValid)
        else $error("restore not answered");
    AST_RESTORE_CAUSE: assert property (restoreValid |-> $past(coreCmd.restoreOp))
        else $error("restore pulse without restore");
    AST_KEEP_STATUS: assert property (
        restoreValid |-> pflagOut[4:3] == $past(pflagIn[4:3]))
        else $error("status bits restored from buffer");
    AST_WAKE: assert property (wakeUp |-> $past(powerDown))
        else $error("wake pulse outside power-down");
    COV_VECTOR: cover property (vectorLoad);
    COV_RESTORE: cover property (restoreValid);
    COV_WAKE: cover property (wakeUp);
endmodule : tsi_unit_props
bind tsi_unit tsi_unit_props u_props (.sysClk(sysClk), .rst(rst), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .coreCmd(coreCmd),
    .pflagIn(pflagIn), .irqReq(irqReq), .vectorLoad(vectorLoad), .vectorAddr(vectorAddr),
    .restoreValid(restoreValid), .pflagOut(pflagOut), .powerDown(powerDown), .wakeUp(wakeUp));
`default_nettype wire

// [tb/tsi_core_model.sv]
// processor core model: boundaries, request acceptance, return and save commands
`timescale 1ns/100ps
`default_nettype none
module tsi_core_model (
    // clock, reset, request
    input wire logic sysClk,
    input wire logic rst,
    input wire logic irqReq,
    // instruction requests from the bench
    input wire logic retReq,
    input wire logic saveReq,
    input wire logic restoreReq,
    output tsi_pkg::tsi_core_cmd_t coreCmd
);
    logic boundary_q;
    logic busy_q;
    always_ff @(posedge sysClk or posedge rst) begin
        if (rst) begin
            boundary_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            boundary_q <= ~boundary_q;
            if (coreCmd.takeAck)
                busy_q <= 1'b1;
            else if (retReq)
                busy_q <= 1'b0;
        end
    end
    // irqReq rises only in the cycle after a boundary, so the core takes it there;
    // never while a routine runs
    assign coreCmd = '{boundary: boundary_q, takeAck: irqReq && !busy_q,
        retIrq: retReq, saveOp: saveReq, restoreOp: restoreReq};
endmodule : tsi_core_model
`default_nettype wire

// [tb/tsi_unit_tb_top.sv]
// testbench for the interrupt unit
`timescale 1ns/100ps
`default_nettype none
module tsi_unit_tb_top;
    logic sysClk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, timerAOvf = 0, timerBOvf = 0, extPin = 1, powerDown = 0;
    logic retReq = 0, saveReq = 0, restoreReq = 0, irqReq, vectorLoad, restoreValid, wakeUp;
    logic [7:0] accIn = 0, pflagIn = 0, accOut, pflagOut;
    logic [15:0] vectorAddr;
    tsi_pkg::tsi_core_cmd_t coreCmd;
    int failures = 0, checkCount = 0, cycles = 0, vectCount = 0, wakeCount = 0;
    always #20 sysClk = ~sysClk;
    tsi_unit dut (.sysClk(sysClk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timerAOvf(timerAOvf), .timerBOvf(timerBOvf), .extPin(extPin), .powerDown(powerDown),
        .coreCmd(coreCmd), .accIn(accIn), .pflagIn(pflagIn), .irqReq(irqReq),
        .vectorLoad(vectorLoad), .vectorAddr(vectorAddr), .restoreValid(restoreValid),
        .accOut(accOut), .pflagOut(pflagOut), .wakeUp(wakeUp));
    tsi_core_model core (.sysClk(sysClk), .rst(rst), .irqReq(irqReq), .retReq(retReq),
        .saveReq(saveReq), .restoreReq(restoreReq), .coreCmd(coreCmd));
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    always @(posedge sysClk) begin
        cycles++;
        if (vectorLoad === 1'b1)
            vectCount++;
        if (wakeUp === 1'b1)
            wakeCount++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sysClk);
    endtask : tick
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // one apb transfer; the slave decides when it answers
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
        // an idle cycle first, so a release and the next setup never share an edge
        @(posedge sysClk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, wd};
        @(posedge sysClk);
        penable <= 1'b1;
        do @(posedge sysClk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input string nm, input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(nm, rd, {24'h0, exp});
    endtask : rdc
    initial begin
        tick(4);
        rst <= 1'b0;
        tick(1);
        rdc("edge reset", tsi_pkg::ADDR_EDGE_SELECT, 8'h10);
        rdc("flags reset", tsi_pkg::ADDR_REQUEST_FLAGS, 8'h00);
        rdc("enables reset", tsi_pkg::ADDR_SOURCE_ENABLES, 8'h00);
        rdc("stack reset", tsi_pkg::ADDR_STACK_GIE, 8'h03);
        rdc("unmapped", 12'h004, 8'h00);
        apb(1'b1, tsi_pkg::ADDR_SOURCE_ENABLES, 8'hff);
        rdc("enables rw", tsi_pkg::ADDR_SOURCE_ENABLES, 8'h31);
        apb(1'b1, tsi_pkg::ADDR_SOURCE_ENABLES, 8'h00);
        // codes 00, 01, 10, 11: bit 1 picks falling, bit 0 rising
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, tsi_pkg::ADDR_EDGE_SELECT, 8'(m << 3));
            extPin <= 1'b0;
            tick(6);
            rdc("fall flag", tsi_pkg::ADDR_REQUEST_FLAGS, 8'(m >> 1));
            apb(1'b1, tsi_pkg::ADDR_REQUEST_FLAGS, 8'h00);
            extPin <= 1'b1;
            tick(6);
            rdc("rise flag", tsi_pkg::ADDR_REQUEST_FLAGS, 8'(m & 1));
            apb(1'b1, tsi_pkg::ADDR_REQUEST_FLAGS, 8'h00);
        end
        timerAOvf <= 1'b1;
        tick(1);
        timerAOvf <= 1'b0;
        timerBOvf <= 1'b1;
        tick(1);
        timerBOvf <= 1'b0;
        tick(20);
        rdc("timer flags held", tsi_pkg::ADDR_REQUEST_FLAGS, 8'h30);
        apb(1'b1, tsi_pkg::ADDR_SOURCE_ENABLES, 8'h10);
        tick(6);
        chk("no vector without global", 32'(vectCount), 32'd0);
        apb(1'b1, tsi_pkg::ADDR_STACK_GIE, 8'h83);
        while (vectCount == 0)
            tick(1);
        chk("vector address", {16'h0, vectorAddr}, {16'h0, tsi_pkg::IRQ_VECTOR});
        rdc("stack in service", tsi_pkg::ADDR_STACK_GIE, 8'h02);
        apb(1'b1, tsi_pkg::ADDR_REQUEST_FLAGS, 8'h00);
        retReq <= 1'b1;
        tick(1);
        retReq <= 1'b0;
        tick(2);
        rdc("stack after return", tsi_pkg::ADDR_STACK_GIE, 8'h83);
        chk("single vector", 32'(vectCount), 32'd1);
        accIn <= 8'h5a;
        pflagIn <= 8'he7;
        saveReq <= 1'b1;
        tick(1);
        saveReq <= 1'b0;
        accIn <= 8'h00;
        pflagIn <= 8'h18;
        restoreReq <= 1'b1;
        tick(1);
        restoreReq <= 1'b0;
        tick(2);
        chk("acc restored", {24'h0, accOut}, 32'h5a);
        chk("flags restored", {24'h0, pflagOut}, 32'hff);
        rdc("save status", tsi_pkg::ADDR_SAVE_STATUS, 8'he7);
        apb(1'b1, tsi_pkg::ADDR_EDGE_SELECT, 8'h18);
        powerDown <= 1'b1;
        extPin <= 1'b0;
        tick(8);
        chk("wake", 32'(wakeCount > 0), 32'd1);
        powerDown <= 1'b0;
        rdc("wake latched", tsi_pkg::ADDR_REQUEST_FLAGS, 8'h01);
        apb(1'b1, tsi_pkg::ADDR_SOURCE_ENABLES, 8'h01);
        while (vectCount == 1)
            tick(1);
        rdc("pin serviced", tsi_pkg::ADDR_STACK_GIE, 8'h02);
        report_and_stop();
    end
endmodule : tsi_unit_tb_top
`default_nettype wire
